// File: src/auto_level_param_bank.sv
`timescale 1ns/100ps
// Overview of operation
// [R1] Width per selected region, 8 to 5120, reset 8.
// [R2] Table mode: 0 off, 1 gamma, 2 user table; reset off.
// [R3] Loop speed 1 to 8, reset 4, shared by gain and exposure; 8 fastest.
// [R4] Exposure upper limit 11 to 8000000 us, reset 18000, capped by frame rate.
// [R5] Exposure lower limit 10 to 7999999 us, reset 100.
// [R6] Read-only exposure outcome code 0..6, reset 0.
// [R7] Trigger option: 0 none, 2 paired exposure; reset 0.
// [R8] Level target percent 1 to 100, reset 50.
// [R9] Gain upper limit 200 to 1600, reset 1600.
// [R10] Gain lower limit 100 to 1500, reset 100.
// [R11] Read-only gain outcome code 0..6, reset 0.
// [R12] Height and offsets for up to eight regions; out-of-range writes rejected.
// [R13] One-bit colour matrix enable, reset off.
module auto_level_param_bank (
  input wire logic clk, // Core clock, 10 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic clkEn, // Freezes all state while low.
  input wire logic [7:0] addr, // Register byte address.
  input wire logic [31:0] writeData, // Write data.
  input wire logic writeStrobe, // One-cycle write request.
  input wire logic readStrobe, // One-cycle read request.
  output logic [31:0] readData, // Read data, valid cycle after strobe.
  input wire logic [31:0] exposureMaxFrame, // Frame-rate ceiling on exposure, same clock.
  input wire logic [2:0] exposureResult, // Exposure loop outcome code, same clock.
  input wire logic exposureResultValid, // Pulse: new exposure outcome.
  input wire logic [2:0] gainResult, // Gain loop outcome code, same clock.
  input wire logic gainResultValid, // Pulse: new gain outcome.
  output logic [3:0] regionCountLimit, // Number of active regions.
  output logic [1:0] tableModeSelect, // Lookup-table mode.
  output logic colourMatrixEnable, // Colour matrix on.
  output logic [3:0] levelLoopSpeed, // Level loop speed.
  output logic [22:0] autoExposureUpper, // Effective exposure upper limit.
  output logic [22:0] autoExposureLower, // Exposure lower limit.
  output logic [1:0] triggerOptionSelect, // Trigger option.
  output logic [6:0] levelTargetPercent, // Level target.
  output logic [10:0] autoGainUpper, // Gain upper limit.
  output logic [10:0] autoGainLower, // Gain lower limit.
  output logic irq // Level interrupt.
);

  // ----------------------------------------
  // Range check
  // ----------------------------------------
  function automatic logic inRange(input logic [31:0] v, input logic [31:0] lo,
                                   input logic [31:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  region_mem_if mem ();

  region_store #(.DEPTH(8)) store (
    .clk(clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .mem(mem)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [3:0] countLimit, next_countLimit;
  logic [2:0] regionIndex, next_regionIndex;
  logic [1:0] tableMode, next_tableMode;
  logic matrixEn, next_matrixEn;
  logic [3:0] speed, next_speed;
  logic [22:0] expUpper, next_expUpper;
  logic [22:0] expLower, next_expLower;
  logic [2:0] expOutcome, next_expOutcome;
  logic [1:0] trigOpt, next_trigOpt;
  logic [6:0] target, next_target;
  logic [10:0] gainUpper, next_gainUpper;
  logic [10:0] gainLower, next_gainLower;
  logic [2:0] irqStatus, next_irqStatus;
  logic [2:0] irqMask, next_irqMask;
  logic [2:0] gainOutcome, next_gainOutcome;
  logic readRegion, next_readRegion;
  logic [31:0] directData, next_directData;
  logic [22:0] next_effUpper;
  logic reject;

  // ----------------------------------------
  // Region memory access
  // ----------------------------------------
  always_comb begin
    mem.index = regionIndex;
    mem.field = 2'h0;
    mem.writeEn = 1'b0;
    mem.writeData = writeData[12:0];
    case (addr)
      param_bank_pkg::ADDR_REGION_WIDTH: begin
        // [R1] Width range check.
        mem.writeEn = writeStrobe &&
            inRange(writeData, param_bank_pkg::WIDTH_MIN, param_bank_pkg::WIDTH_MAX);
      end
      param_bank_pkg::ADDR_REGION_HEIGHT: begin
        mem.field = 2'h1;
        // [R12] Height range check.
        mem.writeEn = writeStrobe && inRange(writeData, 32'h0, param_bank_pkg::HEIGHT_MAX);
      end
      param_bank_pkg::ADDR_REGION_OFFSET_HORIZ: begin
        mem.field = 2'h2;
        // [R12] Offset range check.
        mem.writeEn = writeStrobe && inRange(writeData, 32'h0, param_bank_pkg::OFFSET_H_MAX);
      end
      param_bank_pkg::ADDR_REGION_OFFSET_VERT: begin
        mem.field = 2'h3;
        mem.writeEn = writeStrobe && inRange(writeData, 32'h0, param_bank_pkg::OFFSET_V_MAX);
      end
      default: begin
        mem.field = 2'h0;
      end
    endcase
  end

  // ----------------------------------------
  // Register writes and status
  // ----------------------------------------
  always_comb begin
    next_countLimit = countLimit;
    next_regionIndex = regionIndex;
    next_tableMode = tableMode;
    next_matrixEn = matrixEn;
    next_speed = speed;
    next_expUpper = expUpper;
    next_expLower = expLower;
    next_expOutcome = expOutcome;
    next_gainOutcome = gainOutcome;
    next_trigOpt = trigOpt;
    next_target = target;
    next_gainUpper = gainUpper;
    next_gainLower = gainLower;
    next_irqMask = irqMask;
    next_irqStatus = irqStatus;
    reject = 1'b0;
    if (writeStrobe) begin
      case (addr)
        param_bank_pkg::ADDR_REGION_COUNT_LIMIT: begin
          reject = !inRange(writeData, param_bank_pkg::REGION_COUNT_MIN,
                            param_bank_pkg::REGION_COUNT_MAX);
          next_countLimit = reject ? countLimit : writeData[3:0];
        end
        param_bank_pkg::ADDR_REGION_INDEX: begin
          reject = writeData >= param_bank_pkg::REGION_COUNT_MAX;
          next_regionIndex = reject ? regionIndex : writeData[2:0];
        end
        param_bank_pkg::ADDR_REGION_WIDTH, param_bank_pkg::ADDR_REGION_HEIGHT,
        param_bank_pkg::ADDR_REGION_OFFSET_HORIZ,
        param_bank_pkg::ADDR_REGION_OFFSET_VERT: begin
          reject = !mem.writeEn;
        end
        param_bank_pkg::ADDR_TABLE_MODE_SELECT: begin
          // [R2] Only the three encodings.
          reject = writeData > 32'(param_bank_pkg::TABLE_USER);
          next_tableMode = reject ? tableMode : writeData[1:0];
        end
        param_bank_pkg::ADDR_COLOUR_MATRIX_ENABLE: begin
          // [R13] Single-bit enable.
          reject = writeData > 32'h1;
          next_matrixEn = reject ? matrixEn : writeData[0];
        end
        param_bank_pkg::ADDR_LEVEL_LOOP_SPEED: begin
          // [R3] Speed range.
          reject = !inRange(writeData, param_bank_pkg::SPEED_MIN, param_bank_pkg::SPEED_MAX);
          next_speed = reject ? speed : writeData[3:0];
        end
        param_bank_pkg::ADDR_AUTO_EXPOSURE_UPPER: begin
          // [R4] Exposure upper range.
          reject = !inRange(writeData, param_bank_pkg::EXP_UPPER_MIN,
                            param_bank_pkg::EXP_UPPER_MAX);
          next_expUpper = reject ? expUpper : writeData[22:0];
        end
        param_bank_pkg::ADDR_AUTO_EXPOSURE_LOWER: begin
          // [R5] Exposure lower range.
          reject = !inRange(writeData, param_bank_pkg::EXP_LOWER_MIN,
                            param_bank_pkg::EXP_LOWER_MAX);
          next_expLower = reject ? expLower : writeData[22:0];
        end
        param_bank_pkg::ADDR_TRIGGER_OPTION_SELECT: begin
          // [R7] Off or paired exposure only.
          reject = writeData != 32'(param_bank_pkg::TRIG_OPT_OFF) &&
              writeData != 32'(param_bank_pkg::TRIG_OPT_PAIRED);
          next_trigOpt = reject ? trigOpt : writeData[1:0];
        end
        param_bank_pkg::ADDR_LEVEL_TARGET_PERCENT: begin
          // [R8] Target percent range.
          reject = !inRange(writeData, param_bank_pkg::TARGET_MIN, param_bank_pkg::TARGET_MAX);
          next_target = reject ? target : writeData[6:0];
        end
        param_bank_pkg::ADDR_AUTO_GAIN_UPPER: begin
          // [R9] Gain upper range.
          reject = !inRange(writeData, param_bank_pkg::GAIN_UPPER_MIN,
                            param_bank_pkg::GAIN_UPPER_MAX);
          next_gainUpper = reject ? gainUpper : writeData[10:0];
        end
        param_bank_pkg::ADDR_AUTO_GAIN_LOWER: begin
          // [R10] Gain lower range.
          reject = !inRange(writeData, param_bank_pkg::GAIN_LOWER_MIN,
                            param_bank_pkg::GAIN_LOWER_MAX);
          next_gainLower = reject ? gainLower : writeData[10:0];
        end
        param_bank_pkg::ADDR_IRQ_STATUS: begin
          next_irqStatus = irqStatus & ~writeData[2:0];
        end
        param_bank_pkg::ADDR_IRQ_MASK: begin
          next_irqMask = writeData[2:0];
        end
        default: begin
          reject = 1'b1;
        end
      endcase
    end
    // [R6] Outcome codes come only from the loop; software cannot write them.
    if (exposureResultValid) begin
      next_expOutcome = exposureResult;
    end
    // [R11] Gain outcome capture.
    if (gainResultValid) begin
      next_gainOutcome = gainResult;
    end
    // Sets are applied after the clear so an event in the clearing cycle is kept.
    if (reject) begin
      next_irqStatus[param_bank_pkg::IRQ_BIT_REJECT] = 1'b1;
    end
    if (exposureResultValid) begin
      next_irqStatus[param_bank_pkg::IRQ_BIT_EXP_DONE] = 1'b1;
    end
    if (gainResultValid) begin
      next_irqStatus[param_bank_pkg::IRQ_BIT_GAIN_DONE] = 1'b1;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    next_readRegion = 1'b0;
    next_directData = 32'h0;
    if (readStrobe) begin
      case (addr)
        param_bank_pkg::ADDR_REGION_COUNT_LIMIT: next_directData = 32'(countLimit);
        param_bank_pkg::ADDR_REGION_INDEX: next_directData = 32'(regionIndex);
        param_bank_pkg::ADDR_REGION_WIDTH, param_bank_pkg::ADDR_REGION_HEIGHT,
        param_bank_pkg::ADDR_REGION_OFFSET_HORIZ,
        param_bank_pkg::ADDR_REGION_OFFSET_VERT: next_readRegion = 1'b1;
        param_bank_pkg::ADDR_TABLE_MODE_SELECT: next_directData = 32'(tableMode);
        param_bank_pkg::ADDR_COLOUR_MATRIX_ENABLE: next_directData = 32'(matrixEn);
        param_bank_pkg::ADDR_LEVEL_LOOP_SPEED: next_directData = 32'(speed);
        param_bank_pkg::ADDR_AUTO_EXPOSURE_UPPER: next_directData = 32'(expUpper);
        param_bank_pkg::ADDR_AUTO_EXPOSURE_LOWER: next_directData = 32'(expLower);
        param_bank_pkg::ADDR_AUTO_EXPOSURE_OUTCOME: next_directData = 32'(expOutcome);
        param_bank_pkg::ADDR_TRIGGER_OPTION_SELECT: next_directData = 32'(trigOpt);
        param_bank_pkg::ADDR_LEVEL_TARGET_PERCENT: next_directData = 32'(target);
        param_bank_pkg::ADDR_AUTO_GAIN_UPPER: next_directData = 32'(gainUpper);
        param_bank_pkg::ADDR_AUTO_GAIN_LOWER: next_directData = 32'(gainLower);
        param_bank_pkg::ADDR_AUTO_GAIN_OUTCOME: next_directData = 32'(gainOutcome);
        param_bank_pkg::ADDR_IRQ_STATUS: next_directData = 32'(irqStatus);
        param_bank_pkg::ADDR_IRQ_MASK: next_directData = 32'(irqMask);
        default: next_directData = 32'h0;
      endcase
    end
    // [R4] Frame rate caps the usable upper limit.
    next_effUpper = expUpper;
    if (32'(expUpper) > exposureMaxFrame) begin
      next_effUpper = exposureMaxFrame[22:0];
    end
  end

  // Both sources are registers, so the word stands only in the cycle after the strobe.
  assign readData = readRegion ? 32'(mem.readData) : directData;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      countLimit <= 4'(param_bank_pkg::REGION_COUNT_RST);
      regionIndex <= 3'h0;
      tableMode <= 2'(param_bank_pkg::TABLE_OFF);
      matrixEn <= 1'b0;
      speed <= 4'(param_bank_pkg::SPEED_RST);
      expUpper <= 23'(param_bank_pkg::EXP_UPPER_RST);
      expLower <= 23'(param_bank_pkg::EXP_LOWER_RST);
      expOutcome <= 3'(param_bank_pkg::OUT_COMPLETE);
      gainOutcome <= 3'(param_bank_pkg::OUT_COMPLETE);
      trigOpt <= param_bank_pkg::TRIG_OPT_OFF;
      target <= 7'(param_bank_pkg::TARGET_RST);
      gainUpper <= 11'(param_bank_pkg::GAIN_UPPER_RST);
      gainLower <= 11'(param_bank_pkg::GAIN_LOWER_RST);
      irqStatus <= 3'h0;
      irqMask <= 3'h0;
      readRegion <= 1'b0;
      directData <= 32'h0;
      regionCountLimit <= 4'(param_bank_pkg::REGION_COUNT_RST);
      tableModeSelect <= 2'(param_bank_pkg::TABLE_OFF);
      colourMatrixEnable <= 1'b0;
      levelLoopSpeed <= 4'(param_bank_pkg::SPEED_RST);
      autoExposureUpper <= 23'(param_bank_pkg::EXP_UPPER_RST);
      autoExposureLower <= 23'(param_bank_pkg::EXP_LOWER_RST);
      triggerOptionSelect <= param_bank_pkg::TRIG_OPT_OFF;
      levelTargetPercent <= 7'(param_bank_pkg::TARGET_RST);
      autoGainUpper <= 11'(param_bank_pkg::GAIN_UPPER_RST);
      autoGainLower <= 11'(param_bank_pkg::GAIN_LOWER_RST);
      irq <= 1'b0;
    end else if (clkEn) begin
      countLimit <= next_countLimit;
      regionIndex <= next_regionIndex;
      tableMode <= next_tableMode;
      matrixEn <= next_matrixEn;
      speed <= next_speed;
      expUpper <= next_expUpper;
      expLower <= next_expLower;
      expOutcome <= next_expOutcome;
      gainOutcome <= next_gainOutcome;
      trigOpt <= next_trigOpt;
      target <= next_target;
      gainUpper <= next_gainUpper;
      gainLower <= next_gainLower;
      irqStatus <= next_irqStatus;
      irqMask <= next_irqMask;
      readRegion <= next_readRegion;
      directData <= next_directData;
      regionCountLimit <= countLimit;
      tableModeSelect <= tableMode;
      colourMatrixEnable <= matrixEn;
      levelLoopSpeed <= speed;
      autoExposureUpper <= next_effUpper;
      autoExposureLower <= expLower;
      triggerOptionSelect <= trigOpt;
      levelTargetPercent <= target;
      autoGainUpper <= gainUpper;
      autoGainLower <= gainLower;
      irq <= |(irqStatus & irqMask);
    end
  end

endmodule

// File: src/param_bank_pkg.sv
package param_bank_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_REGION_COUNT_LIMIT = 8'h00;
  localparam logic [7:0] ADDR_REGION_INDEX = 8'h04;
  localparam logic [7:0] ADDR_REGION_WIDTH = 8'h08;
  localparam logic [7:0] ADDR_REGION_HEIGHT = 8'h0C;
  localparam logic [7:0] ADDR_REGION_OFFSET_HORIZ = 8'h10;
  localparam logic [7:0] ADDR_REGION_OFFSET_VERT = 8'h14;
  localparam logic [7:0] ADDR_TABLE_MODE_SELECT = 8'h18;
  localparam logic [7:0] ADDR_COLOUR_MATRIX_ENABLE = 8'h1C;
  localparam logic [7:0] ADDR_LEVEL_LOOP_SPEED = 8'h20;
  localparam logic [7:0] ADDR_AUTO_EXPOSURE_UPPER = 8'h24;
  localparam logic [7:0] ADDR_AUTO_EXPOSURE_LOWER = 8'h28;
  localparam logic [7:0] ADDR_AUTO_EXPOSURE_OUTCOME = 8'h2C;
  localparam logic [7:0] ADDR_TRIGGER_OPTION_SELECT = 8'h30;
  localparam logic [7:0] ADDR_LEVEL_TARGET_PERCENT = 8'h34;
  localparam logic [7:0] ADDR_AUTO_GAIN_UPPER = 8'h38;
  localparam logic [7:0] ADDR_AUTO_GAIN_LOWER = 8'h3C;
  localparam logic [7:0] ADDR_AUTO_GAIN_OUTCOME = 8'h40;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h44;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h48;

  // ----------------------------------------
  // Ranges and reset values
  // ----------------------------------------
  localparam logic [31:0] REGION_COUNT_MIN = 32'h1;
  localparam logic [31:0] REGION_COUNT_MAX = 32'h8;
  localparam logic [31:0] REGION_COUNT_RST = 32'h1;
  localparam logic [31:0] WIDTH_MIN = 32'd8;
  localparam logic [31:0] WIDTH_MAX = 32'd5120;
  localparam logic [31:0] WIDTH_RST = 32'd8;
  localparam logic [31:0] HEIGHT_MAX = 32'd3840;
  localparam logic [31:0] HEIGHT_RST = 32'd1;
  localparam logic [31:0] OFFSET_H_MAX = 32'd5118;
  localparam logic [31:0] OFFSET_V_MAX = 32'd3839;
  localparam logic [31:0] SPEED_MIN = 32'd1;
  localparam logic [31:0] SPEED_MAX = 32'd8;
  localparam logic [31:0] SPEED_RST = 32'd4;
  localparam logic [31:0] EXP_UPPER_MIN = 32'd11;
  localparam logic [31:0] EXP_UPPER_MAX = 32'd8000000;
  localparam logic [31:0] EXP_UPPER_RST = 32'd18000;
  localparam logic [31:0] EXP_LOWER_MIN = 32'd10;
  localparam logic [31:0] EXP_LOWER_MAX = 32'd7999999;
  localparam logic [31:0] EXP_LOWER_RST = 32'd100;
  localparam logic [31:0] TARGET_MIN = 32'd1;
  localparam logic [31:0] TARGET_MAX = 32'd100;
  localparam logic [31:0] TARGET_RST = 32'd50;
  localparam logic [31:0] GAIN_UPPER_MIN = 32'd200;
  localparam logic [31:0] GAIN_UPPER_MAX = 32'd1600;
  localparam logic [31:0] GAIN_UPPER_RST = 32'd1600;
  localparam logic [31:0] GAIN_LOWER_MIN = 32'd100;
  localparam logic [31:0] GAIN_LOWER_MAX = 32'd1500;
  localparam logic [31:0] GAIN_LOWER_RST = 32'd100;

  // Interrupt status bit positions.
  localparam int IRQ_BIT_REJECT = 0;
  localparam int IRQ_BIT_EXP_DONE = 1;
  localparam int IRQ_BIT_GAIN_DONE = 2;

  typedef enum logic [1:0] {
    TABLE_OFF,
    TABLE_GAMMA,
    TABLE_USER
  } table_mode_t;

  typedef enum logic [2:0] {
    OUT_COMPLETE,
    OUT_TOO_BRIGHT,
    OUT_TOO_DARK,
    OUT_TIMEOUT,
    OUT_BUSY,
    OUT_LIMIT,
    OUT_TRIG_NOT_NORMAL
  } outcome_t;

  localparam logic [1:0] TRIG_OPT_OFF = 2'h0;
  localparam logic [1:0] TRIG_OPT_PAIRED = 2'h2;

endpackage

// File: src/region_mem_if.sv
`timescale 1ns/100ps
interface region_mem_if;
  logic [2:0] index;
  logic [1:0] field;
  logic writeEn;
  logic [12:0] writeData;
  logic [12:0] readData;

  modport owner(output index, output field, output writeEn, output writeData, input readData);
  modport store(input index, input field, input writeEn, input writeData, output readData);
endinterface

// File: src/region_store.sv
`timescale 1ns/100ps
module region_store #(
  parameter int DEPTH = 8
) (
  input wire logic clk, // Core clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic clkEn, // Freezes the store while low.
  region_mem_if.store mem // Access port.
);

  // Fields 0..3: width, height, horizontal offset, vertical offset.
  logic [12:0] cells [DEPTH*4];
  logic [12:0] readData;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        cells[i*4] <= 13'(param_bank_pkg::WIDTH_RST);
        cells[i*4+1] <= 13'(param_bank_pkg::HEIGHT_RST);
        cells[i*4+2] <= 13'h0;
        cells[i*4+3] <= 13'h0;
      end
      readData <= 13'h0;
    end else if (clkEn) begin
      if (mem.writeEn) begin
        cells[{mem.index, mem.field}] <= mem.writeData;
      end
      readData <= cells[{mem.index, mem.field}];
    end
  end

  assign mem.readData = readData;

endmodule

// File: test/auto_level_param_bank_props.sv
`timescale 1ns/100ps
module auto_level_param_bank_props (
  input wire logic clk, // Core clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic clkEn, // Run enable.
  input wire logic [7:0] addr, // Register address.
  input wire logic [31:0] writeData, // Write data.
  input wire logic writeStrobe, // Write request.
  input wire logic readStrobe, // Read request.
  input wire logic [31:0] readData, // Read data.
  input wire logic [31:0] exposureMaxFrame, // Frame-rate ceiling.
  input wire logic [1:0] tableModeSelect, // Table mode.
  input wire logic [3:0] levelLoopSpeed, // Loop speed.
  input wire logic [22:0] autoExposureUpper, // Exposure upper limit.
  input wire logic [22:0] autoExposureLower, // Exposure lower limit.
  input wire logic [1:0] triggerOptionSelect, // Trigger option.
  input wire logic [6:0] levelTargetPercent, // Level target.
  input wire logic [10:0] autoGainUpper, // Gain upper limit.
  input wire logic [10:0] autoGainLower, // Gain lower limit.
  input wire logic irq // Interrupt.
);
  // ----------------------------------------
  // Port properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic wrOk;
  assign wrOk = writeStrobe && clkEn;

  a_reset_values: assert property ($rose(resetn) |-> levelLoopSpeed == 4'h4 &&
    levelTargetPercent == 7'h32 && autoGainUpper == 11'h640) else $error("bad reset values");
  a_speed_range: assert property (levelLoopSpeed inside {[1:8]})
    else $error("speed out of range");
  a_target_range: assert property (levelTargetPercent inside {[1:100]})
    else $error("target out of range");
  a_gain_range: assert property (autoGainUpper inside {[200:1600]} &&
    autoGainLower inside {[100:1500]}) else $error("gain limit out of range");
  a_exp_lower_range: assert property (autoExposureLower inside {[10:7999999]})
    else $error("exposure lower out of range");
  a_exp_cap: assert property ($stable(exposureMaxFrame) ##1 $stable(exposureMaxFrame)
    |-> autoExposureUpper <= exposureMaxFrame) else $error("exposure upper above ceiling");
  a_trig_legal: assert property (triggerOptionSelect inside {2'h0, 2'h2})
    else $error("illegal trigger option");
  a_table_legal: assert property (tableModeSelect != 2'h3)
    else $error("illegal table mode");
  a_speed_write: assert property (wrOk && addr == 8'h20 && writeData inside {[1:8]}
    ##1 clkEn |-> ##1 levelLoopSpeed == $past(writeData[3:0], 2)) else $error("speed not taken");
  a_speed_reject: assert property (wrOk && addr == 8'h20 && !(writeData inside {[1:8]})
    ##1 clkEn |-> ##1 $stable(levelLoopSpeed)) else $error("bad speed taken");
  a_mask_quiet: assert property (wrOk && addr == 8'h48 && writeData[2:0] == 3'h0
    ##1 clkEn |-> ##1 !irq) else $error("masked interrupt raised");

  cover property (wrOk && addr == 8'h20);
  cover property ($rose(irq));
  cover property (readStrobe && addr == 8'hFC);
endmodule

bind auto_level_param_bank auto_level_param_bank_props u_props (.clk, .resetn, .clkEn, .addr,
  .writeData, .writeStrobe, .readStrobe, .readData, .exposureMaxFrame, .tableModeSelect,
  .levelLoopSpeed, .autoExposureUpper, .autoExposureLower, .triggerOptionSelect,
  .levelTargetPercent, .autoGainUpper, .autoGainLower, .irq);

// File: test/tb.sv
`timescale 1ns/100ps
module tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] writeData = 32'h0;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  logic [31:0] exposureMaxFrame = 32'h7A1200;
  logic [2:0] exposureResult = 3'h0;
  logic exposureResultValid = 1'b0;
  logic [2:0] gainResult = 3'h0;
  logic gainResultValid = 1'b0;
  logic [31:0] readData, got;
  logic [3:0] regionCountLimit, levelLoopSpeed;
  logic [1:0] tableModeSelect, triggerOptionSelect;
  logic colourMatrixEnable, irq;
  logic [22:0] autoExposureUpper, autoExposureLower;
  logic [6:0] levelTargetPercent;
  logic [10:0] autoGainUpper, autoGainLower;
  int errors = 0;
  int checksDone = 0;
  // Rejected writes must leave the last accepted value, so bad rows follow a good one except at 0x14, 0x2C, 0x40 and 0xFC, which expect 0.
  row_t rows[] = '{
    '{8'h20, 32'h8, 32'h8}, '{8'h20, 32'h9, 32'h8}, '{8'h20, 32'h1, 32'h1},
    '{8'h20, 32'h0, 32'h1}, '{8'h24, 32'hB, 32'hB}, '{8'h24, 32'hA, 32'hB},
    '{8'h24, 32'h7A1200, 32'h7A1200}, '{8'h24, 32'h7A1201, 32'h7A1200},
    '{8'h28, 32'hA, 32'hA}, '{8'h28, 32'h9, 32'hA}, '{8'h28, 32'h7A11FF, 32'h7A11FF},
    '{8'h28, 32'h7A1200, 32'h7A11FF}, '{8'h18, 32'h1, 32'h1}, '{8'h18, 32'h2, 32'h2},
    '{8'h18, 32'h3, 32'h2}, '{8'h30, 32'h2, 32'h2}, '{8'h30, 32'h1, 32'h2},
    '{8'h34, 32'h64, 32'h64}, '{8'h34, 32'h65, 32'h64}, '{8'h34, 32'h0, 32'h64},
    '{8'h38, 32'hC8, 32'hC8}, '{8'h38, 32'hC7, 32'hC8}, '{8'h38, 32'h641, 32'hC8},
    '{8'h3C, 32'h5DC, 32'h5DC}, '{8'h3C, 32'h5DD, 32'h5DC}, '{8'h3C, 32'h63, 32'h5DC},
    '{8'h08, 32'h1400, 32'h1400}, '{8'h08, 32'h1401, 32'h1400}, '{8'h08, 32'h7, 32'h1400},
    '{8'h1C, 32'h1, 32'h1}, '{8'h00, 32'h8, 32'h8}, '{8'h00, 32'h9, 32'h8},
    '{8'h04, 32'h7, 32'h7}, '{8'h0C, 32'hF00, 32'hF00}, '{8'h0C, 32'hF01, 32'hF00},
    '{8'h10, 32'h13FE, 32'h13FE}, '{8'h10, 32'h13FF, 32'h13FE}, '{8'h14, 32'hF00, 32'h0},
    '{8'h2C, 32'h5, 32'h0}, '{8'h40, 32'h5, 32'h0}, '{8'hFC, 32'h5, 32'h0}
  };

  auto_level_param_bank DUT (.clk, .resetn, .clkEn, .addr, .writeData, .writeStrobe,
    .readStrobe, .readData, .exposureMaxFrame, .exposureResult, .exposureResultValid,
    .gainResult, .gainResultValid, .regionCountLimit, .tableModeSelect, .colourMatrixEnable,
    .levelLoopSpeed, .autoExposureUpper, .autoExposureLower, .triggerOptionSelect,
    .levelTargetPercent, .autoGainUpper, .autoGainLower, .irq);

  always #50 clk = ~clk;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clk);
    writeStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    addr <= a;
    readStrobe <= 1'b1;
    @(posedge clk);
    readStrobe <= 1'b0;
    #1 chk(n, e, readData);
  endtask
  task automatic pulse(input logic ev, input logic gv, input logic [2:0] e, input logic [2:0] g);
    @(posedge clk);
    exposureResult <= e;
    gainResult <= g;
    exposureResultValid <= ev;
    gainResultValid <= gv;
    @(posedge clk);
    exposureResultValid <= 1'b0;
    gainResultValid <= 1'b0;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic resetCheck;
    resetn <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    settle();
    chk("speed", 32'h4, 32'(levelLoopSpeed));
    chk("target", 32'h32, 32'(levelTargetPercent));
    chk("exposure upper", 32'h4650, 32'(autoExposureUpper));
    chk("exposure lower", 32'h64, 32'(autoExposureLower));
    chk("gain upper", 32'h640, 32'(autoGainUpper));
    chk("gain lower", 32'h64, 32'(autoGainLower));
    chk("modes", 32'h0, {27'h0, tableModeSelect, colourMatrixEnable, triggerOptionSelect});
    chk("region count", 32'h1, 32'(regionCountLimit));
    chk("irq", 32'h0, {31'h0, irq});
    $display("test reset done");
  endtask
  task automatic stopTest;
    $display("checks %0d mismatches %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    resetCheck();
    rd(8'h2C, 32'h0, "exposure outcome");
    rd(8'h40, 32'h0, "gain outcome");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, $sformatf("register %h", rows[i].a));
    end
    $display("test table done");
    chk("modes set", 32'h116, {23'h0, regionCountLimit, tableModeSelect, colourMatrixEnable, triggerOptionSelect});
    for (int c = 0; c < 7; c++) begin
      pulse(1'b1, 1'b1, 3'(c), 3'(6 - c));
      rd(8'h2C, 32'(c), "exposure outcome");
      rd(8'h40, 32'(6 - c), "gain outcome");
    end
    $display("test outcomes done");
    // Status already holds all three events; only the mask decides the line.
    wr(8'h48, 32'h7);
    settle();
    chk("irq raised", 32'h1, {31'h0, irq});
    rd(8'h44, 32'h7, "irq status");
    wr(8'h44, 32'h7);
    wr(8'h48, 32'h2);
    settle();
    chk("irq cleared", 32'h0, {31'h0, irq});
    pulse(1'b0, 1'b1, 3'h4, 3'h4);
    settle();
    chk("irq masked", 32'h0, {31'h0, irq});
    pulse(1'b1, 1'b0, 3'h5, 3'h5);
    settle();
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(8'h48, 32'h0);
    settle();
    chk("irq mask off", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    exposureMaxFrame <= 32'h1388;
    settle();
    chk("exposure cap", 32'h1388, 32'(autoExposureUpper));
    exposureMaxFrame <= 32'h7A1200;
    settle();
    chk("exposure uncapped", 32'h7A1200, 32'(autoExposureUpper));
    $display("test ceiling done");
    clkEn <= 1'b0;
    wr(8'h20, 32'h2);
    clkEn <= 1'b1;
    rd(8'h20, 32'h1, "frozen speed");
    $display("test freeze done");
    resetCheck();
    rd(8'h20, 32'h4, "speed after reset");
    stopTest();
  end

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    stopTest();
  end
endmodule
